// [src/t2rc_top.v]
// 16-bit reload/capture timer with avalon-mm registers and interrupt
//
// Behaviour
// - running: mode from baud selects and capture select, autoreload default
// - autoreload rollover sets overflow flag and loads the reload pair
// - autoreload with trigger enabled: falling trigger reloads, sets event flag
// - capture mode counts 16 bits, overflow sets flag, flag can interrupt
// - capture mode falling trigger copies count bytes into capture pair
// - that falling trigger also sets event flag, which can interrupt
// - either baud select set enters baud-rate mode
// - baud-rate mode never sets overflow flag on rollover
// - baud-rate mode event flag still raises interrupts
// - count clock is the core clock
`timescale 1ns/1ps
`include "t2rc_regs.vh"
module t2rc_top (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // avalon-mm slave
   input wire [`T2RC_ADDR_W-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [`T2RC_DATA_W-1:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output wire [`T2RC_DATA_W-1:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   // external trigger pin
   input wire external_trigger_input_i,
   // status outputs
   output wire irq_o,
   output wire [15:0] count_o
);

   // control bits
   reg run_control_reg;
   reg run_control_next;
   reg capture_select_reg;
   reg capture_select_next;
   reg receive_baud_select_reg;
   reg receive_baud_select_next;
   reg transmit_baud_select_reg;
   reg transmit_baud_select_next;
   reg external_trigger_enable_reg;
   reg external_trigger_enable_next;

   // flags and mask
   reg timer_overflow_flag_reg;
   reg timer_overflow_flag_next;
   reg external_event_flag_reg;
   reg external_event_flag_next;
   reg [1:0] mask_reg;
   reg [1:0] mask_next;
   reg irq_reg;
   reg irq_next;

   // count and reload/capture pair
   reg [15:0] count_reg;
   reg [15:0] count_next;
   reg [7:0] low_capture_register_reg;
   reg [7:0] low_capture_register_next;
   reg [7:0] high_capture_register_reg;
   reg [7:0] high_capture_register_next;

   // bus answer
   reg avs_waitrequest_reg;
   reg avs_waitrequest_next;
   reg [`T2RC_DATA_W-1:0] avs_readdata_reg;
   reg [`T2RC_DATA_W-1:0] avs_readdata_next;

   // trigger edge detection
   reg trig_prev_reg;
   wire trig_sync;
   wire trig_fall;
   wire ext_event;

   // decode
   wire bus_accept;
   wire bus_wr;
   wire sel_ctrl;
   wire sel_status;
   wire sel_mask;
   wire sel_count;
   wire sel_capture;
   wire sel_mode;
   wire wr_lo;
   wire wr_hi;
   wire baud_sel;
   wire rollover;
   wire [7:0] count_low_byte;
   wire [7:0] count_high_byte;
   reg [1:0] mode;

   t2rc_sync #(
      .WIDTH(1),
      .RST_VAL(`T2RC_TRIG_RST)
   ) u_trig_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i(external_trigger_input_i),
      .sync_o(trig_sync)
   );

   // a request is answered one cycle after it is seen; the write
   // lands on the edge where the master sees waitrequest low
   assign bus_accept = (avs_read_i | avs_write_i) & avs_waitrequest_reg;
   assign bus_wr = avs_write_i & ~avs_waitrequest_reg;
   assign sel_ctrl = (avs_address_i == `T2RC_OFF_CTRL);
   assign sel_status = (avs_address_i == `T2RC_OFF_STATUS);
   assign sel_mask = (avs_address_i == `T2RC_OFF_MASK);
   assign sel_count = (avs_address_i == `T2RC_OFF_COUNT);
   assign sel_capture = (avs_address_i == `T2RC_OFF_CAPTURE);
   assign sel_mode = (avs_address_i == `T2RC_OFF_MODE);
   assign wr_lo = bus_wr & avs_byteenable_i[`T2RC_BE_LO];
   assign wr_hi = bus_wr & avs_byteenable_i[`T2RC_BE_HI];

   assign count_low_byte = count_reg[7:0];
   assign count_high_byte = count_reg[15:8];

   assign baud_sel = receive_baud_select_reg | transmit_baud_select_reg;

   // the count clock is clk_i itself, one step per edge
   assign rollover = run_control_reg & (count_reg == `T2RC_CNT_MAX);

   // trigger edges count only after synchronising, so a short glitch
   // narrower than one clock may be missed
   assign trig_fall = trig_prev_reg & ~trig_sync;
   assign ext_event = trig_fall & external_trigger_enable_reg;

   // mode select
   always @*
   begin
      mode = `T2RC_MODE_OFF;
      if (run_control_reg)
      begin
         if (baud_sel)
            mode = `T2RC_MODE_BAUD;
         else if (capture_select_reg)
            mode = `T2RC_MODE_CAPT;
         else
            mode = `T2RC_MODE_AUTO;
      end
   end

   // counter and reload/capture pair
   always @*
   begin
      count_next = count_reg;
      low_capture_register_next = low_capture_register_reg;
      high_capture_register_next = high_capture_register_reg;
      case (mode)
         `T2RC_MODE_OFF:
         begin
            count_next = count_reg;
         end
         `T2RC_MODE_AUTO:
         begin
            if (rollover | ext_event)
               count_next = {high_capture_register_reg,
                  low_capture_register_reg};
            else
               count_next = count_reg + `T2RC_CNT_ONE;
         end
         `T2RC_MODE_CAPT:
         begin
            // plain wrap through zero on overflow
            count_next = count_reg + `T2RC_CNT_ONE;
         end
         `T2RC_MODE_BAUD:
         begin
            if (rollover)
               count_next = {high_capture_register_reg,
                  low_capture_register_reg};
            else
               count_next = count_reg + `T2RC_CNT_ONE;
         end
         default:
         begin
            count_next = count_reg;
         end
      endcase
      // software write of the count wins over counting
      if (sel_count & wr_lo)
         count_next[7:0] = avs_writedata_i[7:0];
      if (sel_count & wr_hi)
         count_next[15:8] = avs_writedata_i[15:8];
      if (sel_capture & wr_lo)
         low_capture_register_next = avs_writedata_i[7:0];
      if (sel_capture & wr_hi)
         high_capture_register_next = avs_writedata_i[15:8];
      // a hardware capture wins over a software write in the same cycle
      if ((mode == `T2RC_MODE_CAPT) & ext_event)
      begin
         low_capture_register_next = count_low_byte;
         high_capture_register_next = count_high_byte;
      end
   end

   // control, mask, flags and interrupt
   always @*
   begin
      run_control_next = run_control_reg;
      capture_select_next = capture_select_reg;
      receive_baud_select_next = receive_baud_select_reg;
      transmit_baud_select_next = transmit_baud_select_reg;
      external_trigger_enable_next = external_trigger_enable_reg;
      mask_next = mask_reg;
      timer_overflow_flag_next = timer_overflow_flag_reg;
      external_event_flag_next = external_event_flag_reg;
      if (sel_ctrl & wr_lo)
      begin
         run_control_next = avs_writedata_i[`T2RC_CTRL_RUN];
         capture_select_next = avs_writedata_i[`T2RC_CTRL_CAP];
         receive_baud_select_next = avs_writedata_i[`T2RC_CTRL_RXB];
         transmit_baud_select_next = avs_writedata_i[`T2RC_CTRL_TXB];
         external_trigger_enable_next = avs_writedata_i[`T2RC_CTRL_EXEN];
      end
      if (sel_mask & wr_lo)
      begin
         mask_next[`T2RC_STAT_TOF] = avs_writedata_i[`T2RC_STAT_TOF];
         mask_next[`T2RC_STAT_EXT] = avs_writedata_i[`T2RC_STAT_EXT];
      end
      // write one to clear, hardware never clears
      if (sel_status & wr_lo)
      begin
         if (avs_writedata_i[`T2RC_STAT_TOF])
            timer_overflow_flag_next = `T2RC_BIT_RST;
         if (avs_writedata_i[`T2RC_STAT_EXT])
            external_event_flag_next = `T2RC_BIT_RST;
      end
      // set after clear so a same-cycle event is never lost
      if (rollover & (mode != `T2RC_MODE_BAUD))
         timer_overflow_flag_next = 1'b1;
      if (ext_event)
         external_event_flag_next = 1'b1;
      irq_next = (timer_overflow_flag_next & mask_next[`T2RC_STAT_TOF]) |
         (external_event_flag_next & mask_next[`T2RC_STAT_EXT]);
   end

   // bus answer and read mux
   always @*
   begin
      avs_waitrequest_next = ~bus_accept;
      avs_readdata_next = avs_readdata_reg;
      if (bus_accept)
      begin
         avs_readdata_next = `T2RC_RDATA_RST;
         if (sel_ctrl)
         begin
            avs_readdata_next[`T2RC_CTRL_RUN] = run_control_reg;
            avs_readdata_next[`T2RC_CTRL_CAP] = capture_select_reg;
            avs_readdata_next[`T2RC_CTRL_RXB] = receive_baud_select_reg;
            avs_readdata_next[`T2RC_CTRL_TXB] = transmit_baud_select_reg;
            avs_readdata_next[`T2RC_CTRL_EXEN] =
               external_trigger_enable_reg;
         end
         if (sel_status)
         begin
            avs_readdata_next[`T2RC_STAT_TOF] = timer_overflow_flag_reg;
            avs_readdata_next[`T2RC_STAT_EXT] = external_event_flag_reg;
         end
         if (sel_mask)
            avs_readdata_next[1:0] = mask_reg;
         if (sel_count)
            avs_readdata_next[15:0] = count_reg;
         if (sel_capture)
            avs_readdata_next[15:0] = {high_capture_register_reg,
               low_capture_register_reg};
         if (sel_mode)
            avs_readdata_next[1:0] = mode;
      end
   end

   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         run_control_reg <= `T2RC_BIT_RST;
         capture_select_reg <= `T2RC_BIT_RST;
         receive_baud_select_reg <= `T2RC_BIT_RST;
         transmit_baud_select_reg <= `T2RC_BIT_RST;
         external_trigger_enable_reg <= `T2RC_BIT_RST;
         timer_overflow_flag_reg <= `T2RC_BIT_RST;
         external_event_flag_reg <= `T2RC_BIT_RST;
         mask_reg <= `T2RC_MASK_RST;
         irq_reg <= `T2RC_BIT_RST;
         count_reg <= `T2RC_CNT_RST;
         low_capture_register_reg <= `T2RC_BYTE_RST;
         high_capture_register_reg <= `T2RC_BYTE_RST;
         avs_waitrequest_reg <= `T2RC_WAIT_RST;
         avs_readdata_reg <= `T2RC_RDATA_RST;
         trig_prev_reg <= `T2RC_TRIG_RST;
      end
      else
      begin
         run_control_reg <= run_control_next;
         capture_select_reg <= capture_select_next;
         receive_baud_select_reg <= receive_baud_select_next;
         transmit_baud_select_reg <= transmit_baud_select_next;
         external_trigger_enable_reg <= external_trigger_enable_next;
         timer_overflow_flag_reg <= timer_overflow_flag_next;
         external_event_flag_reg <= external_event_flag_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
         count_reg <= count_next;
         low_capture_register_reg <= low_capture_register_next;
         high_capture_register_reg <= high_capture_register_next;
         avs_waitrequest_reg <= avs_waitrequest_next;
         avs_readdata_reg <= avs_readdata_next;
         trig_prev_reg <= trig_sync;
      end
   end

   assign avs_readdata_o = avs_readdata_reg;
   assign avs_waitrequest_o = avs_waitrequest_reg;
   assign irq_o = irq_reg;
   assign count_o = count_reg;

endmodule // t2rc_top

// [src/t2rc_regs.vh]
// constants for the reload/capture timer: offsets, bit positions, codes
`ifndef T2RC_REGS_VH
`define T2RC_REGS_VH

`define T2RC_ADDR_W 5
`define T2RC_DATA_W 32

`define T2RC_OFF_CTRL 5'h00
`define T2RC_OFF_STATUS 5'h04
`define T2RC_OFF_MASK 5'h08
`define T2RC_OFF_COUNT 5'h0C
`define T2RC_OFF_CAPTURE 5'h10
`define T2RC_OFF_MODE 5'h14

`define T2RC_CTRL_RUN 0
`define T2RC_CTRL_CAP 1
`define T2RC_CTRL_RXB 2
`define T2RC_CTRL_TXB 3
`define T2RC_CTRL_EXEN 4

`define T2RC_STAT_TOF 0
`define T2RC_STAT_EXT 1

`define T2RC_BE_LO 0
`define T2RC_BE_HI 1

`define T2RC_MODE_OFF 2'h0
`define T2RC_MODE_AUTO 2'h1
`define T2RC_MODE_CAPT 2'h2
`define T2RC_MODE_BAUD 2'h3

`define T2RC_CNT_MAX 16'hFFFF
`define T2RC_CNT_ONE 16'h0001
`define T2RC_CNT_RST 16'h0000
`define T2RC_BYTE_RST 8'h00
`define T2RC_BIT_RST 1'b0
`define T2RC_TRIG_RST 1'b1
`define T2RC_WAIT_RST 1'b1
`define T2RC_MASK_RST 2'h0
`define T2RC_RDATA_RST 32'h00000000

`endif

// [src/t2rc_sync.v]
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module t2rc_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // levels
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // first stage feeds only the second stage
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule // t2rc_sync

// [sim/t2rc_props.sv]
// port-level assertions for the reload/capture timer
`timescale 1ns/1ps
module t2rc_props (
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // avalon-mm slave
   input wire [4:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   // pin and status
   input wire external_trigger_input_i,
   input wire irq_o,
   input wire [15:0] count_o
);
   // shadows land on the same edge as the write, so they match the dut
   reg [4:0] ctrl_reg;
   reg [1:0] mask_reg;
   wire wacc = avs_write_i && !avs_waitrequest_o;
   wire lo_wr = wacc && avs_byteenable_i[0];
   wire cnt_wr = wacc && avs_address_i == 5'h0C
      && avs_byteenable_i[1:0] != 2'h0;
   wire baud = ctrl_reg[2] | ctrl_reg[3];
   always @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_reg <= 5'h00;
         mask_reg <= 2'h0;
      end
      else if (lo_wr && avs_address_i == 5'h00)
         ctrl_reg <= avs_writedata_i[4:0];
      else if (lo_wr && avs_address_i == 5'h08)
         mask_reg <= avs_writedata_i[1:0];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence req_s;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence ans_s;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   // trigger reloads only in autoreload with the enable set
   property step_p;
      ctrl_reg[0] && !cnt_wr && count_o != 16'hFFFF
      && (ctrl_reg[1] || baud || !ctrl_reg[4])
      |=> count_o == $past(count_o) + 16'h1;
   endproperty
   property wrap_p;
      ctrl_reg[0] && ctrl_reg[1] && !baud && count_o == 16'hFFFF
      && !cnt_wr |=> count_o == 16'h0000;
   endproperty
   ans_pulse_a: assert property (req_s |=> ans_s)
      else $error("request not answered by one low wait cycle");
   no_req_a: assert property (!avs_read_i && !avs_write_i
      |=> avs_waitrequest_o) else $error("wait low without request");
   hold_count_a: assert property (!ctrl_reg[0] && !cnt_wr
      |=> $stable(count_o)) else $error("count moved while stopped");
   count_step_a: assert property (step_p)
      else $error("count did not step by one");
   capt_wrap_a: assert property (wrap_p)
      else $error("capture mode did not wrap to zero");
   baud_tof_a: assert property (baud && mask_reg == 2'h1 && !irq_o
      && !wacc |=> !irq_o) else $error("overflow flag set in baud mode");
   irq_mask_a: assert property (mask_reg == 2'h0 |-> !irq_o)
      else $error("interrupt with all sources masked");
   irq_hold_a: assert property (irq_o && !wacc |=> irq_o)
      else $error("flag cleared without software");
endmodule // t2rc_props

// [sim/t2rc_pin_model.sv]
// trigger pin source: idles high, gives a four-cycle low pulse on request
`timescale 1ns/1ps
module t2rc_pin_model (
   // clock
   input wire clk_i,
   // request
   input wire fire_i,
   // pin
   output reg pin_o = 1'b1
);
   // low and high each span well over two cycles so the sync sees both
   reg [2:0] low_cnt = 3'h0;
   always @(posedge clk_i)
   begin
      if (fire_i)
         low_cnt <= 3'h4;
      else if (low_cnt != 3'h0)
         low_cnt <= low_cnt - 3'h1;
      pin_o <= (fire_i || low_cnt > 3'h1) ? 1'b0 : 1'b1;
   end
endmodule // t2rc_pin_model

// [sim/t2rc_tb_top.sv]
// self-checking bench for the reload/capture timer
`timescale 1ns/1ps
module t2rc_tb_top;
   reg clk_i = 1'b0;
   reg nrst_i = 1'b0;
   reg [4:0] addr = 5'h00;
   reg rd_en = 1'b0;
   reg wr_en = 1'b0;
   reg [31:0] wdata = 32'h0;
   reg [3:0] be = 4'hF;
   reg fire = 1'b0;
   wire pin;
   wire [31:0] rdata;
   wire wait_o;
   wire irq;
   wire [15:0] count;
   integer seed = 32'h3a08;
   integer miscompares = 0;
   integer compares = 0;
   integer cyc = 0;
   integer t_acc = 0;
   integer i;
   reg [31:0] exp_q[$];
   reg [15:0] v;
   reg [6:0] tbl [0:4] = '{7'h05, 7'h0E, 7'h17, 7'h27, 7'h37};
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   t2rc_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(addr),
      .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_o), .external_trigger_input_i(pin),
      .irq_o(irq), .count_o(count));
   t2rc_pin_model pm (.clk_i(clk_i), .fire_i(fire), .pin_o(pin));
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
   begin
      compares = compares + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task stop_test;
   begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   // request held until wait is sampled low; bounded by the watchdog
   task bus(input w, input [4:0] a, input [31:0] d, input [3:0] b);
   begin
      @(posedge clk_i);
      addr <= a;
      wr_en <= w;
      rd_en <= !w;
      wdata <= d;
      be <= b;
      do @(posedge clk_i); while (wait_o !== 1'b0);
      t_acc = cyc;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   end
   endtask
   task wr(input [4:0] a, input [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task rd(input [4:0] a, input [31:0] e);
   begin
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0, 4'hF);
   end
   endtask
   task fire_pin;
   begin
      @(posedge clk_i);
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
   end
   endtask
   task wait_irq;
   begin
      i = 0;
      while (irq !== 1'b1 && i < 200)
      begin
         @(negedge clk_i);
         i = i + 1;
      end
      chk("irq", irq, 32'h1);
   end
   endtask
   always @(posedge clk_i)
      if (rd_en && wait_o === 1'b0)
         chk("rdata", rdata, exp_q.pop_front());
   initial
   begin
      #250000;
      miscompares = miscompares + 1;
      stop_test;
   end
   initial
   begin
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (i = 0; i < 7; i = i + 1)
         rd(5'(i * 4), 32'h0);
      rd(5'h02, 32'h0);
      for (i = 0; i < 5; i = i + 1)
      begin
         wr(5'h00, {27'h0, tbl[i][6:2]});
         rd(5'h14, {30'h0, tbl[i][1:0]});
      end
      wr(5'h00, 32'($random(seed)) & 32'h1E);
      rd(5'h14, 32'h0);
      v = 16'($random(seed));
      wr(5'h0C, {16'h0, v});
      repeat (5) @(posedge clk_i);
      bus(1'b1, 5'h0C, 32'hAB00, 4'h2);
      rd(5'h0C, {16'h0, 8'hAB, v[7:0]});
      v = 16'($random(seed)) & 16'h7FFF;
      wr(5'h10, {16'h0, v});
      wr(5'h0C, 32'hFFFD);
      wr(5'h08, 32'h1);
      wr(5'h00, 32'h1);
      wait_irq;
      chk("count", count, {16'h0, v});
      rd(5'h04, 32'h1);
      wr(5'h04, 32'h1);
      rd(5'h04, 32'h0);
      chk("irq", irq, 32'h0);
      v = 16'($random(seed)) & 16'h7FFF;
      wr(5'h10, {16'h0, v});
      wr(5'h08, 32'h2);
      wr(5'h00, 32'h11);
      fire_pin;
      wait_irq;
      chk("count", count, {16'h0, v});
      rd(5'h04, 32'h2);
      wr(5'h04, 32'h2);
      v = 16'($random(seed)) & 16'h7FFF;
      wr(5'h00, 32'h13);
      wr(5'h0C, {16'h0, v});
      fire_pin;
      wait_irq;
      chk("count", count, v + cyc - t_acc - 1);
      rd(5'h10, v + cyc - t_acc - 2);
      rd(5'h04, 32'h2);
      wr(5'h04, 32'h2);
      wr(5'h08, 32'h1);
      wr(5'h0C, 32'hFFFE);
      wait_irq;
      chk("count", count, 32'h0);
      rd(5'h04, 32'h1);
      wr(5'h04, 32'h1);
      // only the overflow source unmasked, so a stray flag shows on irq
      wr(5'h08, 32'h1);
      wr(5'h10, 32'hFFF0);
      wr(5'h00, 32'h15);
      // park near the top so two baud rollovers fall in the window
      wr(5'h0C, 32'hFFF0);
      repeat (40) @(negedge clk_i);
      chk("irq", irq, 32'h0);
      rd(5'h04, 32'h0);
      wr(5'h08, 32'h2);
      fire_pin;
      wait_irq;
      rd(5'h04, 32'h2);
      stop_test;
   end
endmodule // t2rc_tb_top
bind t2rc_top t2rc_props chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
   .external_trigger_input_i(external_trigger_input_i), .count_o(count_o));
